// >>> hdl/alarm_defines.vh
// constants of the alarm contact controller: register map, fields, timing
// assumes a 125 MHz ref_clk and word-indexed register addresses
//
// Functional notes
// [RL1] twelve dedicated inputs plus four contacts each set as input or output
// [RL2] with the expansion panel attached: up to 32 inputs and 16 outputs
// [RL3] input indicator amber while any input is in alarm, off otherwise
// [RL4] output indicator amber while any output is in alarm, off otherwise
// [RL5] per-input polarity: alarm on contact closure or on contact open
// [RL6] per-input severity Critical/Major/Minor/Not Alarmed/Not Reported, attached
// [RL7] per-input flag marks its alarm service affecting or not
// [RL8] per-input description text of up to 63 characters
// [RL9] alarm holds until contact leaves alarm state or input is unprovisioned
// [RL10] each output closes from its trigger or only by manual command
// [RL11] local trigger closes when any local alarm reaches the threshold
// [RL12] remote trigger uses same comparison, remote alarms only
// [RL13] an input may assert one of four virtual wires while in alarm
// [RL14] any virtual wire may be the trigger of an output
// [RL15] each output takes a manual force open or force closed
// [RL16] manual force overrides every provisioned trigger
// [RL17] ring indicators flash green on local or express channel calls
// [RL18] star then four zeros rings every device
// [RL19] star then station number rings only the matching device
// [RL20] fail indicator red in reset, flashing in boot, off when ready
// [RL21] supply indicators green in range, red out of range
// [RL22] activity indicator green while card is provisioned
// [RL23] contact inputs synchronised and debounced before polarity check
`ifndef ALARM_DEFINES_VH
`define ALARM_DEFINES_VH

`define DEBOUNCE_CYC 24'd1250000
`define FLASH_CYC 32'd31250000

// word addresses
`define A_CTRL 12'h000
`define A_STATUS 12'h001
`define A_ALARMS 12'h002
`define A_OUTS 12'h003
`define A_VWIRE 12'h004
`define A_STATION 12'h005
`define A_LOCSEV 12'h006
`define A_REMSEV 12'h007
`define A_INCFG 7'h02
`define A_OUTCFG 8'h06
`define DESC_BIT 11

// control fields
`define C_PANEL 0
`define C_READY 1
`define C_PROV 2
`define C_IODIR 4

// input config fields
`define I_PROV 0
`define I_CLOSE 1
`define I_SEV 2
`define I_SA 5
`define I_VW 6
`define I_VWEN 8

// output config fields
`define O_SRC 0
`define O_THR 2
`define O_VW 5
`define O_FEN 7
`define O_FVAL 8

// trigger sources and severities
`define SRC_LOCAL 2'h1
`define SRC_REMOTE 2'h2
`define SRC_VWIRE 2'h3
`define SEV_NR 3'h0

// dialed tone codes
`define DIG_STAR 4'ha
`define RST_STATION 16'h0001

`endif

// >>> hdl/contact_debounce.v
// one contact input: two-stage synchroniser then a stability debouncer
// assumes an asynchronous pin and the shared ref_clk
`timescale 1ns/1ps
`default_nettype none
module contact_debounce #(
    parameter [23:0] STABLE_CYC = 24'd1250000
) (
    input wire ref_clk, // system clock
    input wire sys_rst, // synchronous reset
    input wire pin_in, // raw contact level
    output reg level_r // debounced level
);
    reg meta_r;
    reg sync_r;
    reg [23:0] cnt_r;

    // first stage feeds only the second stage
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
        end
    end

    // level accepted only after holding steady, so bounce never reaches polarity
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_r <= 24'h0;
            level_r <= 1'b0;
        end else if (sync_r == level_r) begin
            cnt_r <= 24'h0;
        end else if (cnt_r >= STABLE_CYC - 24'h1) begin
            cnt_r <= 24'h0;
            level_r <= sync_r; // RL23
        end else begin
            cnt_r <= cnt_r + 24'h1;
        end
    end
endmodule // contact_debounce
`default_nettype wire

// >>> hdl/ring_detect.v
// dialed-digit matcher for one orderwire channel
// assumes digits arrive as one-cycle strobes from a same-clock tone decoder
`timescale 1ns/1ps
`default_nettype none
`include "alarm_defines.vh"
module ring_detect (
    input wire ref_clk, // system clock
    input wire sys_rst, // synchronous reset
    input wire digit_valid, // one-cycle digit strobe
    input wire [3:0] digit, // 0-9, star code
    input wire [15:0] station, // own number, four bcd digits
    output reg ring_hit_r // one-cycle call pulse
);
    localparam [1:0] S_IDLE = 2'b00;
    localparam [1:0] S_DIGITS = 2'b01;
    reg [1:0] state_r;
    reg [1:0] cnt_r;
    reg [11:0] num_r;
    wire [15:0] full_num = {num_r, digit};

    // star opens a sequence; any later star restarts it
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r <= S_IDLE;
            cnt_r <= 2'h0;
            num_r <= 12'h000;
            ring_hit_r <= 1'b0;
        end else begin
            ring_hit_r <= 1'b0;
            if (digit_valid) begin
                case (state_r)
                    S_IDLE: begin
                        if (digit == `DIG_STAR) begin
                            state_r <= S_DIGITS;
                            cnt_r <= 2'h0;
                        end
                    end
                    S_DIGITS: begin
                        if (digit == `DIG_STAR) begin
                            cnt_r <= 2'h0;
                        end else if (digit > 4'h9) begin
                            state_r <= S_IDLE;
                        end else if (cnt_r == 2'h3) begin
                            state_r <= S_IDLE;
                            ring_hit_r <= (full_num == 16'h0000) // RL18
                                | (full_num == station); // RL19
                        end else begin
                            num_r <= {num_r[7:0], digit};
                            cnt_r <= cnt_r + 2'h1;
                        end
                    end
                    default: state_r <= S_IDLE;
                endcase
            end
        end
    end
endmodule // ring_detect
`default_nettype wire

// >>> hdl/alarm_contact_controller.v
// alarm contact controller: input evaluation, output closure, indicators, ring
// assumes contacts and supply sense are asynchronous pins; bus on ref_clk
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_defines.vh"
module alarm_contact_controller #(
    parameter [23:0] DEBOUNCE_CYC = `DEBOUNCE_CYC,
    parameter [31:0] FLASH_CYC = `FLASH_CYC
) (
    input wire ref_clk, // system clock
    input wire sys_rst, // synchronous reset
    input wire [11:0] reg_addr, // word address
    input wire [31:0] reg_wdata, // write data
    input wire reg_we, // write strobe
    input wire reg_re, // read strobe
    output reg [31:0] reg_rdata_r, // read data, cycle after strobe
    input wire [11:0] base_in, // dedicated input contacts
    input wire [3:0] io_in, // configurable contacts, sensed level
    output wire [3:0] io_out, // configurable contacts, closure drive
    output wire [3:0] io_oe, // high while contact used as output
    input wire [15:0] panel_in, // expansion panel inputs
    output wire [15:0] panel_out, // expansion panel outputs
    input wire supply_a_ok, // supply a in range, async
    input wire supply_b_ok, // supply b in range, async
    input wire dtmf_valid, // digit strobe from tone decoder
    input wire [3:0] dtmf_digit, // decoded digit
    input wire dtmf_express, // digit is from express channel
    output reg input_led_r, // amber input indicator
    output reg output_led_r, // amber output indicator
    output reg fail_led_r, // red fail indicator
    output reg activity_indicator_r, // green activity indicator
    output reg supply_a_indicator_green_r, // supply a green
    output reg supply_a_indicator_red_r, // supply a red
    output reg supply_b_indicator_green_r, // supply b green
    output reg supply_b_indicator_red_r, // supply b red
    output reg local_ring_led_r, // green local ring indicator
    output reg express_ring_led_r, // green express ring indicator
    output reg ringer_r // ringer drive
);
    integer k;
    genvar g;

    // software state
    reg [7:0] ctrl_r;
    reg [15:0] station_r;
    reg [3:0] loc_sev_r;
    reg [3:0] rem_sev_r;
    reg [8:0] in_cfg_r [0:31];
    reg [8:0] out_cfg_r [0:15];
    reg [7:0] desc_mem [0:2047];
    reg [1:0] ring_r;

    // hardware state
    reg [31:0] alarm_r;
    reg [15:0] closed_r;
    reg [3:0] vwire_r;
    reg blink_r;
    reg [31:0] flash_cnt_r;
    reg [1:0] sa_sync_r;
    reg [1:0] sb_sync_r;

    wire panel_en = ctrl_r[`C_PANEL];
    wire [3:0] io_dir = ctrl_r[`C_IODIR +: 4];
    wire [31:0] raw_in = {panel_in, io_in, base_in};
    wire [31:0] deb;
    wire [1:0] ring_hit;

    // contact front end, one debouncer per input
    generate
        for (g = 0; g < 32; g = g + 1) begin : g_in
            contact_debounce #(
                .STABLE_CYC(DEBOUNCE_CYC)
            ) u_deb (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .pin_in(raw_in[g]),
                .level_r(deb[g])
            );
        end
    endgenerate

    // which contacts act as inputs: 12 dedicated, 4 shared, 16 on the panel
    reg [31:0] in_used;
    always @* begin
        in_used = {{16{panel_en}}, ~io_dir, 12'hfff}; // RL1 RL2
    end

    // per-input alarm state from polarity and provisioning
    reg [31:0] alarm_nxt;
    reg [3:0] vwire_nxt;
    reg [2:0] in_sev_max;
    reg in_any;
    always @* begin
        alarm_nxt = 32'h0;
        vwire_nxt = 4'h0;
        in_sev_max = `SEV_NR;
        in_any = 1'b0;
        for (k = 0; k < 32; k = k + 1) begin
            // closure is a high level; alarm follows contact directly
            alarm_nxt[k] = in_used[k] & in_cfg_r[k][`I_PROV] // RL9
                & (deb[k] == in_cfg_r[k][`I_CLOSE]); // RL5
            if (alarm_nxt[k] & in_cfg_r[k][`I_VWEN]) begin
                vwire_nxt[in_cfg_r[k][`I_VW +: 2]] = 1'b1; // RL13
            end
            if (alarm_nxt[k] & (in_cfg_r[k][`I_SEV +: 3] > in_sev_max)) begin
                in_sev_max = in_cfg_r[k][`I_SEV +: 3]; // RL6
            end
            in_any = in_any | alarm_nxt[k];
        end
    end

    // local view: contact alarms plus software-reported local alarms
    wire loc_present = in_any | loc_sev_r[3];
    wire [2:0] loc_max = (loc_sev_r[3] && loc_sev_r[2:0] > in_sev_max) ?
        loc_sev_r[2:0] : in_sev_max;

    // output closure decision per contact
    reg [15:0] closed_nxt;
    reg [2:0] thr;
    reg trig;
    always @* begin
        closed_nxt = 16'h0000;
        thr = `SEV_NR;
        trig = 1'b0;
        for (k = 0; k < 16; k = k + 1) begin
            thr = out_cfg_r[k][`O_THR +: 3];
            case (out_cfg_r[k][`O_SRC +: 2])
                `SRC_LOCAL: trig = loc_present & (loc_max >= thr); // RL11
                `SRC_REMOTE: trig = rem_sev_r[3] & (rem_sev_r[2:0] >= thr); // RL12
                `SRC_VWIRE: trig = vwire_nxt[out_cfg_r[k][`O_VW +: 2]]; // RL14
                default: trig = 1'b0; // RL10
            endcase
            if (out_cfg_r[k][`O_FEN]) begin
                trig = out_cfg_r[k][`O_FVAL]; // RL15 RL16
            end
            // outputs 0-3 close when their shared contact is an output or the panel is attached; rest need the panel
            if (k < 4) begin
                closed_nxt[k] = trig & (io_dir[k] | panel_en); // RL1
            end else begin
                closed_nxt[k] = trig & panel_en; // RL2
            end
        end
    end

    // registered alarm and closure state
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            alarm_r <= 32'h0;
            closed_r <= 16'h0000;
            vwire_r <= 4'h0;
        end else begin
            alarm_r <= alarm_nxt;
            closed_r <= closed_nxt;
            vwire_r <= vwire_nxt;
        end
    end

    // contact drive: shared contacts carry outputs 0-3
    assign io_oe = io_dir;
    assign io_out = closed_r[3:0] & io_dir;
    assign panel_out = closed_r & {16{panel_en}};

    // supply sense synchronisers
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            sa_sync_r <= 2'b00;
            sb_sync_r <= 2'b00;
        end else begin
            sa_sync_r <= {sa_sync_r[0], supply_a_ok};
            sb_sync_r <= {sb_sync_r[0], supply_b_ok};
        end
    end

    // shared flash timebase for fail and ring indicators
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            flash_cnt_r <= 32'h0;
            blink_r <= 1'b0;
        end else if (flash_cnt_r >= FLASH_CYC - 32'h1) begin
            flash_cnt_r <= 32'h0;
            blink_r <= ~blink_r;
        end else begin
            flash_cnt_r <= flash_cnt_r + 32'h1;
        end
    end

    // ring detection per channel; digits steered by channel select
    ring_detect u_ring_loc (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .digit_valid(dtmf_valid & ~dtmf_express),
        .digit(dtmf_digit),
        .station(station_r),
        .ring_hit_r(ring_hit[0])
    );

    ring_detect u_ring_exp (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .digit_valid(dtmf_valid & dtmf_express),
        .digit(dtmf_digit),
        .station(station_r),
        .ring_hit_r(ring_hit[1])
    );

    // register decode
    wire wr_ctrl = reg_we & (reg_addr == `A_CTRL);
    wire wr_stat = reg_we & (reg_addr == `A_STATUS);
    wire wr_in = reg_we & (reg_addr[11:5] == `A_INCFG);
    wire wr_out = reg_we & (reg_addr[11:4] == `A_OUTCFG);
    wire wr_desc = reg_we & reg_addr[`DESC_BIT];

    // call latch: a new call in the clearing cycle survives
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            ring_r <= 2'b00;
        end else begin
            ring_r <= (ring_r & ~({2{wr_stat}} & reg_wdata[3:2])) | ring_hit;
        end
    end

    // software registers
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_r <= 8'h00;
            station_r <= `RST_STATION;
            loc_sev_r <= 4'h0;
            rem_sev_r <= 4'h0;
            for (k = 0; k < 32; k = k + 1) begin
                in_cfg_r[k] <= 9'h000;
            end
            for (k = 0; k < 16; k = k + 1) begin
                out_cfg_r[k] <= 9'h000;
            end
        end else if (reg_we) begin
            if (wr_ctrl) begin
                ctrl_r <= reg_wdata[7:0];
            end
            if (reg_addr == `A_STATION) begin
                station_r <= reg_wdata[15:0];
            end
            if (reg_addr == `A_LOCSEV) begin
                loc_sev_r <= reg_wdata[3:0];
            end
            if (reg_addr == `A_REMSEV) begin
                rem_sev_r <= reg_wdata[3:0];
            end
            if (wr_in) begin
                in_cfg_r[reg_addr[4:0]] <= reg_wdata[8:0]; // RL6 RL7
            end
            if (wr_out) begin
                out_cfg_r[reg_addr[3:0]] <= reg_wdata[8:0];
            end
        end
    end

    // description text, 64 bytes per input, no reset needed
    always @(posedge ref_clk) begin
        if (wr_desc) begin
            desc_mem[reg_addr[10:0]] <= reg_wdata[7:0]; // RL8
        end
    end

    // read mux; unmapped words answer zero
    reg [31:0] rd_nxt;
    always @* begin
        rd_nxt = 32'h0;
        if (reg_addr[`DESC_BIT]) begin
            rd_nxt = {24'h000000, desc_mem[reg_addr[10:0]]};
        end else if (reg_addr[11:5] == `A_INCFG) begin
            rd_nxt = {23'h000000, in_cfg_r[reg_addr[4:0]]};
        end else if (reg_addr[11:4] == `A_OUTCFG) begin
            rd_nxt = {23'h000000, out_cfg_r[reg_addr[3:0]]};
        end else begin
            case (reg_addr)
                `A_CTRL: rd_nxt = {24'h000000, ctrl_r};
                `A_STATUS: rd_nxt = {26'h0000000, sb_sync_r[1], sa_sync_r[1],
                    ring_r, output_led_r, input_led_r};
                `A_ALARMS: rd_nxt = alarm_r;
                `A_OUTS: rd_nxt = {16'h0000, closed_r};
                `A_VWIRE: rd_nxt = {28'h0000000, vwire_r};
                `A_STATION: rd_nxt = {16'h0000, station_r};
                `A_LOCSEV: rd_nxt = {28'h0000000, loc_sev_r};
                `A_REMSEV: rd_nxt = {28'h0000000, rem_sev_r};
                default: rd_nxt = 32'h0;
            endcase
        end
    end

    // read data valid only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata_r <= 32'h0;
        end else if (reg_re) begin
            reg_rdata_r <= rd_nxt;
        end else begin
            reg_rdata_r <= 32'h0;
        end
    end

    // faceplate indicators
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            input_led_r <= 1'b0;
            output_led_r <= 1'b0;
            fail_led_r <= 1'b1; // RL20
            activity_indicator_r <= 1'b0;
            supply_a_indicator_green_r <= 1'b0;
            supply_a_indicator_red_r <= 1'b0;
            supply_b_indicator_green_r <= 1'b0;
            supply_b_indicator_red_r <= 1'b0;
            local_ring_led_r <= 1'b0;
            express_ring_led_r <= 1'b0;
            ringer_r <= 1'b0;
        end else begin
            input_led_r <= |alarm_r; // RL3
            output_led_r <= |closed_r; // RL4
            // flashes while booting, dark once processor reports ready
            fail_led_r <= ~ctrl_r[`C_READY] & blink_r; // RL20
            activity_indicator_r <= ctrl_r[`C_PROV]; // RL22
            supply_a_indicator_green_r <= sa_sync_r[1]; // RL21
            supply_a_indicator_red_r <= ~sa_sync_r[1]; // RL21
            supply_b_indicator_green_r <= sb_sync_r[1]; // RL21
            supply_b_indicator_red_r <= ~sb_sync_r[1]; // RL21
            local_ring_led_r <= ring_r[0] & blink_r; // RL17
            express_ring_led_r <= ring_r[1] & blink_r; // RL17
            ringer_r <= |ring_r; // RL18 RL19
        end
    end
endmodule // alarm_contact_controller
`default_nettype wire

// >>> sim/contact_bank.sv
// far-side contact model: dry contacts that chatter after every change
// assumes the bench sets the wanted closures off the sampling edge
`timescale 1ns/1ps
`default_nettype none
module contact_bank (
    input wire logic ref_clk, // system clock
    input wire logic [31:0] want, // requested closures, 1=closed
    output logic [31:0] pins // contact levels seen by the card
);
    logic [31:0] set_r = 32'h0;
    logic [31:0] last_r = 32'h0;
    logic [1:0] bnc_r = 2'h0;
    logic [31:0] pins_r = 32'h0;
    assign pins = pins_r;
    // changed contacts flicker a few cycles, shorter than the debounce span
    always @(posedge ref_clk) begin
        last_r <= want;
        if (want != last_r)
            bnc_r <= 2'h3;
        else if (bnc_r != 2'h0)
            bnc_r <= bnc_r - 2'h1;
        if (want != last_r || bnc_r != 2'h0)
            pins_r <= pins_r ^ (want ^ set_r);
        else begin
            pins_r <= want;
            set_r <= want;
        end
    end
endmodule // contact_bank
`default_nettype wire

// >>> sim/alarm_props.sv
// checker bound to the alarm contact controller top ports
// assumes one clock domain and synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module alarm_props #(
    parameter [23:0] DEBOUNCE_CYC = 24'd4,
    parameter [31:0] FLASH_CYC = 32'd8
) (
    input wire logic ref_clk, // system clock
    input wire logic sys_rst, // reset
    input wire logic [11:0] reg_addr, // word address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_we, // write strobe
    input wire logic reg_re, // read strobe
    input wire logic [31:0] reg_rdata_r, // read data
    input wire logic [3:0] io_out, // shared contact drive
    input wire logic [3:0] io_oe, // shared contact enable
    input wire logic [15:0] panel_out, // panel outputs
    input wire logic supply_a_ok, // supply a sense
    input wire logic supply_b_ok, // supply b sense
    input wire logic dtmf_valid, // digit strobe
    input wire logic ringer_r, // ringer
    input wire logic local_ring_led_r, // local ring led
    input wire logic express_ring_led_r, // express ring led
    input wire logic output_led_r, // output led
    input wire logic input_led_r, // input led
    input wire logic fail_led_r, // fail led
    input wire logic activity_indicator_r, // activity led
    input wire logic supply_a_indicator_green_r, // supply a green
    input wire logic supply_a_indicator_red_r, // supply a red
    input wire logic supply_b_indicator_green_r, // supply b green
    input wire logic supply_b_indicator_red_r // supply b red
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // lone control write
    sequence s_ctrl_wr;
        reg_we && reg_addr == 12'h000 ##1 !(reg_we && reg_addr == 12'h000);
    endsequence
    property p_rst_state;
        $fell(sys_rst) |-> fail_led_r && io_oe == 4'h0 && !ringer_r && !input_led_r;
    endproperty
    property p_rdata_idle;
        !reg_re |=> reg_rdata_r == 32'h0;
    endproperty
    property p_oe_gate;
        (io_out & ~io_oe) == 4'h0;
    endproperty
    property p_sup_a;
        supply_a_ok [*4] |=> supply_a_indicator_green_r && !supply_a_indicator_red_r;
    endproperty
    property p_sup_b;
        !supply_b_ok [*4] |=> supply_b_indicator_red_r && !supply_b_indicator_green_r;
    endproperty
    property p_ringer;
        $rose(ringer_r) |-> $past(dtmf_valid, 3);
    endproperty
    property p_ring_led;
        (local_ring_led_r || express_ring_led_r) |-> ringer_r;
    endproperty
    property p_act;
        s_ctrl_wr |=> activity_indicator_r == $past(reg_wdata[2], 2);
    endproperty
    property p_ready;
        s_ctrl_wr |=> ($past(reg_wdata[1], 2) |-> !fail_led_r);
    endproperty
    property p_iodir;
        s_ctrl_wr |=> io_oe == $past(reg_wdata[7:4], 2);
    endproperty
    property p_outled;
        (io_out != 4'h0 || panel_out != 16'h0) [*2] |-> output_led_r;
    endproperty
    a_rst_state: assert property (p_rst_state) else $error("reset state wrong");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    a_oe_gate: assert property (p_oe_gate) else $error("drive without enable");
    a_sup_a: assert property (p_sup_a) else $error("supply a colour wrong");
    a_sup_b: assert property (p_sup_b) else $error("supply b colour wrong");
    a_ringer: assert property (p_ringer) else $error("ringer without digit");
    a_ring_led: assert property (p_ring_led) else $error("ring led without ring");
    a_act: assert property (p_act) else $error("activity led wrong");
    a_ready: assert property (p_ready) else $error("fail led lit when ready");
    a_iodir: assert property (p_iodir) else $error("io enable wrong");
    a_outled: assert property (p_outled) else $error("output led off");
    c_ring: cover property ($rose(ringer_r));
    c_ctrl: cover property (s_ctrl_wr);
    c_outled: cover property (output_led_r);
    c_sup_b: cover property (!supply_b_ok);
endmodule // alarm_props
bind alarm_contact_controller alarm_props #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .FLASH_CYC(FLASH_CYC)) u_props (.*);
`default_nettype wire

// >>> sim/tb_alarm_contact_controller.sv
// alarm contact controller bench: register tasks, contacts, dialing
// assumes contact_bank at the far side and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_alarm_contact_controller;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0, reg_rdata_r, want = 32'h0, pins;
    logic reg_we = 1'b0, reg_re = 1'b0, sa = 1'b1, sb = 1'b1;
    logic dtmf_valid = 1'b0, dtmf_express = 1'b0;
    logic [3:0] dtmf_digit = 4'h0, io_in, io_out, io_oe;
    logic [15:0] panel_out;
    logic il, ol, fl, act, sag, sar, sbg, sbr, lrl, erl, rng;
    int miscompares = 0, n_compared = 0;
    // 125 MHz
    always #4 ref_clk = ~ref_clk;
    // shared contact wire: card drive wins where enabled
    assign io_in = (io_oe & io_out) | (~io_oe & pins[15:12]);
    contact_bank u_bank (.ref_clk(ref_clk), .want(want), .pins(pins));
    alarm_contact_controller #(.DEBOUNCE_CYC(24'd4), .FLASH_CYC(32'd8)) u_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_r(reg_rdata_r),
        .base_in(pins[11:0]), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .panel_in(pins[31:16]), .panel_out(panel_out), .supply_a_ok(sa), .supply_b_ok(sb),
        .dtmf_valid(dtmf_valid), .dtmf_digit(dtmf_digit), .dtmf_express(dtmf_express),
        .input_led_r(il), .output_led_r(ol), .fail_led_r(fl), .activity_indicator_r(act),
        .supply_a_indicator_green_r(sag), .supply_a_indicator_red_r(sar),
        .supply_b_indicator_green_r(sbg), .supply_b_indicator_red_r(sbr),
        .local_ring_led_r(lrl), .express_ring_led_r(erl), .ringer_r(rng));
    task automatic conclude;
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, logic [31:0] e, s);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [11:0] a, logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge ref_clk);
        reg_we <= 1'b0;
    endtask
    // bounded field poll; a spent bound ends the run
    task automatic rq(input logic [11:0] a, logic [31:0] m, e);
        logic [31:0] d;
        for (int i = 0; i < 30; i++) begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_re <= 1'b1;
            @(posedge ref_clk);
            reg_re <= 1'b0;
            @(negedge ref_clk);
            d = reg_rdata_r & m;
            if (d === e)
                break;
        end
        chk($sformatf("reg %h", a), e, d);
        if (d !== e)
            conclude();
    endtask
    // star and four digits, back to back
    task automatic dial(input logic ex, logic [19:0] s);
        for (int i = 4; i >= 0; i--) begin
            @(posedge ref_clk);
            dtmf_valid <= 1'b1;
            dtmf_digit <= s[i*4 +: 4];
            dtmf_express <= ex;
        end
        @(posedge ref_clk);
        dtmf_valid <= 1'b0;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        chk("fail led", 32'h1, {31'h0, fl});
        sys_rst <= 1'b0;
        rq(12'h005, 32'hffff_ffff, 32'h0001);
        rq(12'h100, 32'hffff_ffff, 32'h0);
        wr(12'h83e, 32'h5a);
        rq(12'h83e, 32'hff, 32'h5a);
        wr(12'h000, 32'h07);
        rq(12'h000, 32'hff, 32'h07);
        chk("act", 32'h1, {31'h0, act});
        chk("fail", 32'h0, {31'h0, fl});
        wr(12'h040, 32'h18f);
        wr(12'h054, 32'h29);
        rq(12'h002, 32'h0010_0001, 32'h0010_0000);
        rq(12'h001, 32'h1, 32'h1);
        want <= 32'h0010_0001;
        rq(12'h002, 32'h0010_0001, 32'h1);
        rq(12'h004, 32'hf, 32'h4);
        wr(12'h065, 32'h43);
        wr(12'h066, 32'h0d);
        wr(12'h067, 32'h0e);
        wr(12'h007, 32'h0b);
        rq(12'h003, 32'he0, 32'he0);
        chk("panel", 32'he0, {16'h0, panel_out & 16'h00e0});
        wr(12'h066, 32'h11);
        wr(12'h067, 32'h12);
        rq(12'h003, 32'he0, 32'h20);
        wr(12'h065, 32'hc3);
        wr(12'h068, 32'h180);
        rq(12'h003, 32'h120, 32'h100);
        rq(12'h001, 32'h2, 32'h2);
        wr(12'h000, 32'h17);
        wr(12'h060, 32'h180);
        rq(12'h003, 32'h1, 32'h1);
        chk("io", 32'h11, {27'h0, io_oe[0], 3'h0, io_out[0]});
        wr(12'h040, 32'h0);
        rq(12'h002, 32'h1, 32'h0);
        rq(12'h001, 32'h1, 32'h0);
        dial(1'b0, 20'ha0000);
        rq(12'h001, 32'hc, 32'h4);
        chk("ringer", 32'h1, {31'h0, rng});
        wr(12'h001, 32'h4);
        rq(12'h001, 32'hc, 32'h0);
        wr(12'h005, 32'h1234);
        dial(1'b1, 20'ha1234);
        rq(12'h001, 32'hc, 32'h8);
        wr(12'h001, 32'h8);
        dial(1'b0, 20'ha5678);
        repeat (10) @(posedge ref_clk);
        rq(12'h001, 32'hc, 32'h0);
        sa <= 1'b0;
        sb <= 1'b0;
        rq(12'h001, 32'h30, 32'h0);
        chk("supply", 32'h5, {29'h0, sar, sag, sbr});
        conclude();
    end
endmodule // tb_alarm_contact_controller
`default_nettype wire
